// ### logic/gcim_top.sv
// global control, monitor select, interrupt masks and flags of the line transceiver
// Overview of operation
// - power-down bit halts filters and zeros transmit output, memory kept
// - power-down sets on reset; cleared only by host writing zero
// - aux clock rate: 01 gives x16, 10 gives x32, 00 and 11 give x64
// - aux clock rate field returns to 00 on reset
// - monitor codes 0-47 equalizer entries, 48 front end, 49 echo replica
// - monitor codes 50 dfe output, 51 slicer, 52 phase detector, 53 loop filter
// - timer mask bit one blocks its flag from interrupt, zero passes it
// - unmasking a set flag activates interrupt at once
// - masking a set flag releases interrupt if nothing else unmasked is set
// - alarm mask bits 3-0 work like timer masks, upper bits unused
// - timer bits 7-0: general four, three, noise, meter, startup four-one
// - timer flag sets and sticks when its count goes from one to zero
// - host clears timer flag by writing zero; writing one is ignored
// - a timer held at zero does not set its cleared flag again
// - new flag with clear mask activates the interrupt
// - clearing unmasked flag releases interrupt unless another unmasked flag set
// - alarm flag clears on zero write only once its condition has gone
`timescale 1ns/1ps
module gcim_top #(
    parameter int TX_W = 2,
    parameter logic [2:0] PART_IDENT = 3'h5, // arbitrary value
    parameter logic [3:0] HW_REV = 4'h0 // arbitrary value
) (
    input wire logic mclk, // device clock
    input wire logic rst, // sync reset, reset pin or power-on
    input wire logic ce, // clock enable
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [7:0] rdata, // read data
    input wire logic [7:0] timer_at_zero, // timer count is zero
    input wire logic [3:0] alarm_cond, // alarm conditions
    input wire logic [TX_W-1:0] tx_in, // transmit symbol in
    output logic [TX_W-1:0] tx_out, // transmit symbol out
    output logic filter_halt, // stop filter processing
    output logic [1:0] aux_clk_sel, // aux clock rate field
    output logic [6:0] aux_clk_mult, // aux clock multiplier
    output gcim_pkg::gcim_mon_src_t mon_src, // monitor source
    output logic [5:0] mon_eq_index, // equalizer entry
    output logic irq_n // interrupt request, low active
);
    logic pdown_q, pdown_d;
    logic [1:0] hclk_q, hclk_d;
    logic [5:0] smon_q, smon_d;
    logic [7:0] tmask_q, tmask_d;
    logic [3:0] amask_q, amask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [TX_W-1:0] tx_q, tx_d;
    logic [6:0] mult_q, mult_d;
    gcim_pkg::gcim_mon_src_t msrc_q, msrc_d;
    logic [5:0] midx_q, midx_d;

    gcim_flag_if #(.W(gcim_pkg::N_TIMER)) tfi ();
    gcim_flag_if #(.W(gcim_pkg::N_ALARM)) afi ();

    // parameter check at elaboration
    if (TX_W < 1) begin : g_bad_tx_w
        $error("TX_W must be at least 1");
    end

    // address match for a host access
    function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
        hit = stb && (a == off);
    endfunction

    // rate field to multiplier
    function automatic logic [6:0] rate_mult(input logic [1:0] f);
        unique case (f)
            2'h0: rate_mult = gcim_pkg::MULT_X64;
            gcim_pkg::HCLK_X16: rate_mult = gcim_pkg::MULT_X16;
            gcim_pkg::HCLK_X32: rate_mult = gcim_pkg::MULT_X32;
            2'h3: rate_mult = gcim_pkg::MULT_X64;
        endcase
    endfunction

    // monitor code to source
    function automatic gcim_pkg::gcim_mon_src_t mon_decode(input logic [5:0] c);
        if (c <= gcim_pkg::SMON_EQ_LAST) begin
            mon_decode = gcim_pkg::MON_EQ_FILE;
        end else begin
            case (c)
                gcim_pkg::SMON_FRONT: mon_decode = gcim_pkg::MON_FRONT_END;
                gcim_pkg::SMON_ECHO: mon_decode = gcim_pkg::MON_ECHO_REPLICA;
                gcim_pkg::SMON_DFE: mon_decode = gcim_pkg::MON_DFE_SUB;
                gcim_pkg::SMON_SLICER: mon_decode = gcim_pkg::MON_SLICER_IN;
                gcim_pkg::SMON_TR_PD: mon_decode = gcim_pkg::MON_TR_PHASE;
                gcim_pkg::SMON_TR_LF: mon_decode = gcim_pkg::MON_TR_LOOP;
                default: mon_decode = gcim_pkg::MON_NONE;
            endcase
        end
    endfunction

    // control register writes
    always_comb begin
        pdown_d = pdown_q;
        hclk_d = hclk_q;
        smon_d = smon_q;
        tmask_d = tmask_q;
        amask_d = amask_q;
        // host write of zero clears power-down
        if (hit(wr_stb, addr, gcim_pkg::ADDR_GLOBAL)) begin
            pdown_d = wdata[gcim_pkg::POS_PDOWN];
        end
        if (hit(wr_stb, addr, gcim_pkg::ADDR_MON)) begin
            hclk_d = wdata[gcim_pkg::POS_HCLK_LO +: 2];
            smon_d = wdata[gcim_pkg::POS_SMON_LO +: 6];
        end
        if (hit(wr_stb, addr, gcim_pkg::ADDR_TMASK)) begin
            tmask_d = wdata;
        end
        if (hit(wr_stb, addr, gcim_pkg::ADDR_AMASK)) begin
            amask_d = wdata[3:0];
        end
    end

    // datapath outputs from the control state
    always_comb begin
        // transmit forced to zero in power-down
        tx_d = pdown_q ? '0 : tx_in;
        mult_d = rate_mult(hclk_d);
        msrc_d = mon_decode(smon_d);
        midx_d = (smon_d <= gcim_pkg::SMON_EQ_LAST) ? smon_d : 6'h00;
    end

    // read data mux
    always_comb begin
        rdata_d = rdata_q;
        if (rd_stb) begin
            unique case (addr)
                gcim_pkg::ADDR_GLOBAL: rdata_d = {HW_REV, PART_IDENT, pdown_q};
                gcim_pkg::ADDR_MON: rdata_d = {hclk_q, smon_q};
                gcim_pkg::ADDR_TMASK: rdata_d = tmask_q;
                gcim_pkg::ADDR_AMASK: rdata_d = {4'h0, amask_q};
                gcim_pkg::ADDR_TFLAG: rdata_d = tfi.flags;
                gcim_pkg::ADDR_AFLAG: rdata_d = {4'h0, afi.flags};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register all state, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (rst) begin
            pdown_q <= gcim_pkg::RST_PDOWN;
            hclk_q <= gcim_pkg::RST_HCLK;
            smon_q <= gcim_pkg::RST_SMON;
            tmask_q <= gcim_pkg::RST_TMASK;
            amask_q <= gcim_pkg::RST_AMASK;
            rdata_q <= 8'h00;
            tx_q <= '0;
            mult_q <= gcim_pkg::MULT_X64;
            msrc_q <= gcim_pkg::MON_EQ_FILE;
            midx_q <= 6'h00;
        end else if (ce) begin
            pdown_q <= pdown_d;
            hclk_q <= hclk_d;
            smon_q <= smon_d;
            tmask_q <= tmask_d;
            amask_q <= amask_d;
            rdata_q <= rdata_d;
            tx_q <= tx_d;
            mult_q <= mult_d;
            msrc_q <= msrc_d;
            midx_q <= midx_d;
        end
    end

    // flag bank hookup
    // timer flags set on reaching zero
    assign tfi.cond = timer_at_zero;
    assign tfi.mask = tmask_q;
    assign tfi.wdata = wdata;
    assign tfi.clr_stb = hit(wr_stb, addr, gcim_pkg::ADDR_TFLAG);
    assign afi.cond = alarm_cond;
    assign afi.mask = amask_q;
    assign afi.wdata = wdata[3:0];
    assign afi.clr_stb = hit(wr_stb, addr, gcim_pkg::ADDR_AFLAG);

    gcim_flag_bank #(.W(gcim_pkg::N_TIMER), .EDGE(1'b1)) u_tflags (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .fb(tfi)
    );

    gcim_flag_bank #(.W(gcim_pkg::N_ALARM), .EDGE(1'b0)) u_aflags (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .fb(afi)
    );

    // outputs
    assign rdata = rdata_q;
    assign tx_out = tx_q;
    assign filter_halt = pdown_q;
    assign aux_clk_sel = hclk_q;
    assign aux_clk_mult = mult_q;
    assign mon_src = msrc_q;
    assign mon_eq_index = midx_q;
    // interrupt low while any unmasked flag set
    assign irq_n = ~(tfi.pend | afi.pend);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_t0_hit;
        ce && !timer_at_zero[0] ##1 ce && timer_at_zero[0] && !tmask_q[0];
    endsequence

    sequence s_hold_zero_clear;
        ce && $past(ce) && $past(timer_at_zero[0]) && timer_at_zero[0]
            && hit(wr_stb, addr, gcim_pkg::ADDR_TFLAG) && !wdata[0]
            ##1 ce && timer_at_zero[0];
    endsequence

    // power-down, transmit and freeze
    chk_pdown_tx: assert property (ce && filter_halt |=> tx_out == '0)
        else $error("transmit not zero in power-down");
    chk_tx_pass: assert property (ce && !filter_halt |=> tx_out == $past(tx_in))
        else $error("transmit not passed while running");
    chk_pdown_clear: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_GLOBAL) && !wdata[0]
        |=> !filter_halt ##1 1)
        else $error("power-down not cleared by zero write");
    chk_ce_freeze: assert property (!ce |=> filter_halt == $past(filter_halt)
        && aux_clk_sel == $past(aux_clk_sel) && tfi.flags == $past(tfi.flags) && rdata == $past(rdata))
        else $error("state moved while clock enable low");
    chk_pdown_reset: assert property ($past(rst) |-> filter_halt && aux_clk_sel == 2'h0)
        else $error("reset did not set power-down and rate field");

    // rate and monitor decode
    chk_rate_x16: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[7:6] == 2'h1
        |=> aux_clk_mult == gcim_pkg::MULT_X16)
        else $error("rate 01 not x16");
    chk_rate_x32: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[7:6] == 2'h2
        |=> aux_clk_mult == gcim_pkg::MULT_X32)
        else $error("rate 10 not x32");
    chk_rate_zero: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[7:6] == 2'h0
        |=> aux_clk_mult == gcim_pkg::MULT_X64)
        else $error("rate 00 not x64");
    chk_rate_x64: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[7:6] == 2'h3
        |=> aux_clk_mult == gcim_pkg::MULT_X64)
        else $error("rate 11 not x64");
    chk_mon_eq: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[5:0] <= 6'h2F
        |=> mon_src == gcim_pkg::MON_EQ_FILE && mon_eq_index == $past(wdata[5:0]))
        else $error("equalizer monitor entry wrong");
    chk_mon_front: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[5:0] == 6'h30
        |=> mon_src == gcim_pkg::MON_FRONT_END && mon_eq_index == 6'h00)
        else $error("front end monitor code wrong");
    chk_mon_echo: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[5:0] == 6'h31
        |=> mon_src == gcim_pkg::MON_ECHO_REPLICA)
        else $error("echo replica monitor code wrong");
    chk_mon_slicer: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[5:0] == 6'h33
        |=> mon_src == gcim_pkg::MON_SLICER_IN)
        else $error("slicer monitor code wrong");
    chk_mon_loop: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_MON) && wdata[5:0] == 6'h35
        |=> mon_src == gcim_pkg::MON_TR_LOOP)
        else $error("loop filter monitor code wrong");

    // interrupt request and flags
    chk_irq_unmask: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_TMASK)
        && (tfi.flags & ~wdata) != 8'h00 |=> !irq_n)
        else $error("unmasked flag did not raise interrupt");
    chk_irq_mask: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_TMASK) && wdata == 8'hFF
        && !afi.pend && alarm_cond == 4'h0 && timer_at_zero == 8'h00 |=> irq_n)
        else $error("masking all flags kept interrupt");
    chk_amask_bits: assert property (ce && rd_stb && addr == gcim_pkg::ADDR_AMASK |=> rdata[7:4] == 4'h0)
        else $error("alarm mask upper bits not zero");
    chk_timer_set: assert property (s_t0_hit |=> tfi.flags[0] && !irq_n)
        else $error("timer flag or interrupt missing");
    chk_no_reassert: assert property (s_hold_zero_clear |=> !tfi.flags[0])
        else $error("steady zero timer set its flag again");
    chk_alarm_hold: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_AFLAG) && !wdata[0]
        && afi.flags[0] && alarm_cond[0] |=> afi.flags[0])
        else $error("alarm flag cleared while condition held");
    chk_alarm_clear: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_AFLAG) && !wdata[0]
        && !alarm_cond[0] |=> !afi.flags[0])
        else $error("alarm flag kept after its condition had gone");
    chk_irq_clear: assert property (ce && hit(wr_stb, addr, gcim_pkg::ADDR_TFLAG) && wdata == 8'h00
        && !afi.pend && timer_at_zero == 8'h00 && alarm_cond == 4'h0 |=> irq_n)
        else $error("interrupt stayed after clearing all flags");
endmodule

// ### logic/gcim_pkg.sv
// constants and types for the global control and interrupt mask block
package gcim_pkg;
    // register offsets on the host register port
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_MON = 8'h01;
    localparam logic [7:0] ADDR_TMASK = 8'h02;
    localparam logic [7:0] ADDR_AMASK = 8'h03;
    localparam logic [7:0] ADDR_TFLAG = 8'h04;
    localparam logic [7:0] ADDR_AFLAG = 8'h05;
    // field positions
    localparam int POS_PDOWN = 0;
    localparam int POS_PART_LO = 1;
    localparam int POS_REV_LO = 4;
    localparam int POS_SMON_LO = 0;
    localparam int POS_HCLK_LO = 6;
    // widths
    localparam int N_TIMER = 8;
    localparam int N_ALARM = 4;
    // reset values
    localparam logic RST_PDOWN = 1'b1;
    localparam logic [1:0] RST_HCLK = 2'h0;
    localparam logic [5:0] RST_SMON = 6'h00;
    localparam logic [7:0] RST_TMASK = 8'hFF;
    localparam logic [3:0] RST_AMASK = 4'hF;
    // auxiliary clock rate codes and multipliers
    localparam logic [1:0] HCLK_X16 = 2'h1;
    localparam logic [1:0] HCLK_X32 = 2'h2;
    localparam logic [6:0] MULT_X16 = 7'h10;
    localparam logic [6:0] MULT_X32 = 7'h20;
    localparam logic [6:0] MULT_X64 = 7'h40;
    // monitor source codes
    localparam logic [5:0] SMON_EQ_LAST = 6'h2F;
    localparam logic [5:0] SMON_FRONT = 6'h30;
    localparam logic [5:0] SMON_ECHO = 6'h31;
    localparam logic [5:0] SMON_DFE = 6'h32;
    localparam logic [5:0] SMON_SLICER = 6'h33;
    localparam logic [5:0] SMON_TR_PD = 6'h34;
    localparam logic [5:0] SMON_TR_LF = 6'h35;
    // monitor source selected for the serial monitor output
    typedef enum logic [2:0] {
        MON_EQ_FILE = 3'b000,
        MON_FRONT_END = 3'b001,
        MON_ECHO_REPLICA = 3'b010,
        MON_DFE_SUB = 3'b011,
        MON_SLICER_IN = 3'b100,
        MON_TR_PHASE = 3'b101,
        MON_TR_LOOP = 3'b110,
        MON_NONE = 3'b111
    } gcim_mon_src_t;
endpackage

// ### logic/gcim_flag_if.sv
// flag bank connection between the control top and a sticky flag bank
`timescale 1ns/1ps
interface gcim_flag_if #(parameter int W = 8);
    logic [W-1:0] cond;
    logic [W-1:0] mask;
    logic [W-1:0] wdata;
    logic clr_stb;
    logic [W-1:0] flags;
    logic pend;
    modport bank (input cond, input mask, input wdata, input clr_stb, output flags, output pend);
    modport ctrl (output cond, output mask, output wdata, output clr_stb, input flags, input pend);
endinterface

// ### logic/gcim_flag_bank.sv
// sticky interrupt flag bank, edge set (timers) or level set (alarms)
`timescale 1ns/1ps
module gcim_flag_bank #(
    parameter int W = 8,
    parameter bit EDGE = 1'b1
) (
    input wire logic mclk, // device clock
    input wire logic rst, // sync reset
    input wire logic ce, // clock enable
    gcim_flag_if.bank fb // flag connection
);
    logic [W-1:0] flag_q, flag_d, prev_q, prev_d, hold_q, hold_d;
    logic [W-1:0] set_w, clr_w, keep_w;

    // width check at elaboration
    if (W < 1 || W > 8) begin : g_bad_width
        $error("flag bank width must be 1 to 8");
    end

    // next flag state, a set always wins over a clear
    always_comb begin
        prev_d = fb.cond;
        // fresh edges only in edge mode
        // edge mode: count reached zero; level mode: condition present
        set_w = EDGE ? (fb.cond & ~prev_q) : fb.cond;
        keep_w = EDGE ? '0 : fb.cond;
        clr_w = (fb.clr_stb ? ~fb.wdata : '0) | hold_q;
        flag_d = (flag_q & ~(clr_w & ~keep_w)) | set_w;
        hold_d = EDGE ? '0 : (clr_w & keep_w & flag_q);
    end

    // state registers, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_q <= '0;
            prev_q <= '1;
            hold_q <= '0;
        end else if (ce) begin
            flag_q <= flag_d;
            prev_q <= prev_d;
            hold_q <= hold_d;
        end
    end

    assign fb.flags = flag_q;
    assign fb.pend = |(flag_q & ~fb.mask);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_flag_sticky: assert property (ce && !fb.clr_stb && hold_q == '0
        |=> (flag_q & $past(flag_q)) == $past(flag_q))
        else $error("flag dropped without a clear");
    chk_ones_ignored: assert property (ce && fb.clr_stb && fb.wdata == '1 && hold_q == '0
        |=> $past(flag_q) == (flag_q & $past(flag_q)))
        else $error("writing ones cleared a flag");
    chk_level_auto: assert property (!EDGE && ce && hold_q[0] && !fb.cond[0] |=> !flag_q[0])
        else $error("armed alarm flag did not clear when condition ended");
endmodule

// ### test/gcim_host_model.sv
// host processor model driving the register port of the control block
`timescale 1ns/1ps
module gcim_host_model (
    input wire logic mclk, // device clock
    output logic [7:0] addr, // register address
    output logic [7:0] wdata, // write data
    output logic wr_stb, // write strobe
    output logic rd_stb, // read strobe
    input wire logic [7:0] rdata // read data
);
    // bus idle at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // one write cycle, lines scrambled once the strobe drops
    // zero writes clear power-down and flags
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr_stb = 1'b1;
        @(negedge mclk);
        wr_stb = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    // one read cycle, data taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        addr = a;
        rd_stb = 1'b1;
        @(negedge mclk);
        rd_stb = 1'b0;
        d = rdata;
        addr = ~a;
    endtask
endmodule

// ### test/test_global_ctrl_irq_mask_regs.sv
// self-checking bench for the global control and interrupt mask block
`timescale 1ns/1ps
module test_global_ctrl_irq_mask_regs;
    localparam logic [2:0] PART_VAL = 3'h2; // arbitrary value
    localparam logic [3:0] REV_VAL = 4'h3; // arbitrary value
    logic mclk, rst, ce, wr_stb, rd_stb, filter_halt, irq_n;
    logic [7:0] addr, wdata, rdata, timer_at_zero;
    logic [3:0] alarm_cond;
    logic [1:0] tx_in, tx_out, aux_clk_sel;
    logic [6:0] aux_clk_mult;
    logic [5:0] mon_eq_index;
    gcim_pkg::gcim_mon_src_t mon_src;
    int miscompares = 0;
    int checks_done = 0;

    gcim_top #(.TX_W(2), .PART_IDENT(PART_VAL), .HW_REV(REV_VAL)) DUT (
        .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .timer_at_zero(timer_at_zero), .alarm_cond(alarm_cond),
        .tx_in(tx_in), .tx_out(tx_out), .filter_halt(filter_halt), .aux_clk_sel(aux_clk_sel),
        .aux_clk_mult(aux_clk_mult), .mon_src(mon_src), .mon_eq_index(mon_eq_index), .irq_n(irq_n));
    gcim_host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata));

    // 200 MHz device clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // compare of a port value
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // compare of a register read under a bit mask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] d;
        host.rd(a, d);
        checks_done++;
        if ((d & m) !== (exp & m)) begin
            miscompares++;
            $display("[FAIL] %0t reg %h got %h exp %h", $time, a, d, exp);
        end
    endtask

    // reset values at ports and registers
    task automatic t_reset();
        chk_pin({7'h0, filter_halt}, 8'h01, "halt");
        chk_pin({6'h0, tx_out}, 8'h00, "tx zero");
        chk_pin({6'h0, aux_clk_sel}, 8'h00, "rate");
        chk_pin({1'b0, aux_clk_mult}, 8'h40, "mult");
        chk_pin({7'h0, irq_n}, 8'h01, "irq idle");
        chk_reg(gcim_pkg::ADDR_GLOBAL, {REV_VAL, PART_VAL, 1'b1}, 8'hFF);
        chk_reg(gcim_pkg::ADDR_TMASK, 8'hFF, 8'hFF);
        chk_reg(gcim_pkg::ADDR_AMASK, 8'h0F, 8'hFF);
        chk_reg(gcim_pkg::ADDR_TFLAG, 8'h00, 8'hFF);
        chk_reg(8'h06, 8'h00, 8'hFF);
    endtask

    // power-down cleared by zero, set again, read-only bits kept
    task automatic t_pdown();
        host.wr(gcim_pkg::ADDR_GLOBAL, 8'h00);
        @(negedge mclk);
        chk_pin({7'h0, filter_halt}, 8'h00, "run");
        chk_pin({6'h0, tx_out}, 8'h03, "tx pass");
        host.wr(gcim_pkg::ADDR_GLOBAL, 8'hFF);
        @(negedge mclk);
        chk_pin({7'h0, filter_halt}, 8'h01, "halt");
        chk_pin({6'h0, tx_out}, 8'h00, "tx zero");
        chk_reg(gcim_pkg::ADDR_GLOBAL, {REV_VAL, PART_VAL, 1'b1}, 8'hFF);
        host.wr(gcim_pkg::ADDR_GLOBAL, 8'h00);
    endtask

    // every rate code and monitor source boundary
    task automatic t_aux_mon();
        logic [5:0] codes [9] = '{6'h00, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36};
        logic [1:0] r;
        logic [6:0] m;
        logic [2:0] s;
        for (int i = 0; i < 9; i++) begin
            r = i[1:0];
            m = (r == 2'h1) ? 7'h10 : (r == 2'h2) ? 7'h20 : 7'h40;
            s = (codes[i] < 6'h30) ? 3'h0 : (codes[i] > 6'h35) ? 3'h7 : codes[i][2:0] + 3'h1;
            host.wr(gcim_pkg::ADDR_MON, {r, codes[i]});
            chk_pin({1'b0, aux_clk_mult}, {1'b0, m}, "mult");
            chk_pin({5'h0, mon_src}, {5'h0, s}, "source");
            chk_pin({2'h0, mon_eq_index}, (s == 3'h0) ? {2'h0, codes[i]} : 8'h00, "index");
            chk_reg(gcim_pkg::ADDR_MON, {r, codes[i]}, 8'hFF);
        end
    endtask

    // each timer flag: set, mask, unmask, clear, no re-set at zero
    task automatic t_timer();
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            timer_at_zero = b;
            @(negedge mclk);
            chk_reg(gcim_pkg::ADDR_TFLAG, b, 8'hFF);
            chk_pin({7'h0, irq_n}, 8'h01, "masked");
            host.wr(gcim_pkg::ADDR_TMASK, ~b);
            chk_pin({7'h0, irq_n}, 8'h00, "unmask");
            host.wr(gcim_pkg::ADDR_TMASK, 8'hFF);
            chk_pin({7'h0, irq_n}, 8'h01, "mask");
            host.wr(gcim_pkg::ADDR_TMASK, ~b);
            host.wr(gcim_pkg::ADDR_TFLAG, 8'hFF);
            chk_pin({7'h0, irq_n}, 8'h00, "one ignored");
            host.wr(gcim_pkg::ADDR_TFLAG, ~b);
            chk_pin({7'h0, irq_n}, 8'h01, "cleared");
            chk_reg(gcim_pkg::ADDR_TFLAG, 8'h00, 8'hFF);
            timer_at_zero = 8'h00;
            @(negedge mclk);
            timer_at_zero = b;
            @(negedge mclk);
            chk_pin({7'h0, irq_n}, 8'h00, "new edge");
            host.wr(gcim_pkg::ADDR_TFLAG, 8'h00);
            timer_at_zero = 8'h00;
            host.wr(gcim_pkg::ADDR_TMASK, 8'hFF);
        end
    endtask

    // each alarm flag: clear refused while condition stands
    task automatic t_alarm();
        logic [3:0] b;
        for (int j = 0; j < 4; j++) begin
            b = 4'h1 << j;
            host.wr(gcim_pkg::ADDR_AMASK, {4'h0, ~b});
            alarm_cond = b;
            @(negedge mclk);
            chk_pin({7'h0, irq_n}, 8'h00, "alarm irq");
            host.wr(gcim_pkg::ADDR_AFLAG, 8'h00);
            chk_reg(gcim_pkg::ADDR_AFLAG, {4'h0, b}, 8'h0F);
            alarm_cond = 4'h0;
            repeat (2) @(negedge mclk);
            chk_reg(gcim_pkg::ADDR_AFLAG, 8'h00, 8'h0F);
            chk_pin({7'h0, irq_n}, 8'h01, "alarm gone");
            host.wr(gcim_pkg::ADDR_AMASK, 8'hFF);
            chk_reg(gcim_pkg::ADDR_AMASK, 8'h0F, 8'hFF);
        end
    endtask

    // flags in both registers hold the request together
    task automatic t_cross();
        host.wr(gcim_pkg::ADDR_TMASK, 8'hFE);
        host.wr(gcim_pkg::ADDR_AMASK, 8'h0E);
        timer_at_zero = 8'h01;
        alarm_cond = 4'h1;
        @(negedge mclk);
        alarm_cond = 4'h0;
        host.wr(gcim_pkg::ADDR_TFLAG, 8'h00);
        chk_pin({7'h0, irq_n}, 8'h00, "alarm holds");
        host.wr(gcim_pkg::ADDR_AFLAG, 8'h00);
        chk_pin({7'h0, irq_n}, 8'h01, "all clear");
        timer_at_zero = 8'h00;
    endtask

    // reset in mid-run restores power-down and rate
    task automatic t_rerst();
        host.wr(gcim_pkg::ADDR_MON, 8'hC5);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk_pin({6'h0, aux_clk_sel}, 8'h00, "rate rst");
        chk_pin({7'h0, filter_halt}, 8'h01, "halt rst");
        chk_reg(gcim_pkg::ADDR_MON, 8'h00, 8'hC0);
    endtask

    // clock enable low: a host write is not taken
    task automatic t_freeze();
        ce = 1'b0;
        host.wr(gcim_pkg::ADDR_MON, 8'h40);
        chk_pin({1'b0, aux_clk_mult}, 8'h40, "frozen rate");
        ce = 1'b1;
        chk_reg(gcim_pkg::ADDR_MON, 8'h00, 8'hFF);
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #50000;
        miscompares++;
        end_of_test();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        timer_at_zero = 8'h00;
        alarm_cond = 4'h0;
        tx_in = 2'b11;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_pdown();
        t_aux_mon();
        t_timer();
        t_alarm();
        t_cross();
        t_rerst();
        t_freeze();
        end_of_test();
    end
endmodule
